//--- logic/cptg_pkg.sv
// constants and types for the counter pulse train generator
package cptg_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DELAY  = 8'h04;
	localparam logic [7:0] REG_ACTIVE = 8'h08;
	localparam logic [7:0] REG_IDLE   = 8'h0c;
	localparam logic [7:0] REG_COUNT  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_PULSES = 8'h18;
	localparam logic [7:0] REG_LEVEL  = 8'h1c;
	// control field positions
	localparam int CTRL_ARM       = 0;
	localparam int CTRL_SRC_FALL  = 1;
	localparam int CTRL_GATE_FALL = 2;
	localparam int CTRL_TRIG_LSB  = 3;
	localparam int CTRL_EVERY     = 5;
	localparam int CTRL_MODE_LSB  = 6;
	localparam int CTRL_FIN_BUF   = 9;
	localparam int CTRL_REGEN_LSB = 10;
	localparam int CTRL_SCLK_FALL = 12;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0020;
	localparam logic [31:0] TICKS_RESET = 32'h0000_0002;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0001;
	// status field positions
	localparam int ST_RUN   = 0;
	localparam int ST_OUT   = 1;
	localparam int ST_DONE  = 2;
	localparam int ST_UNDER = 3;
	localparam int ST_WAIT  = 4;
	// gate usage
	localparam logic [1:0] TRIG_NONE   = 2'h0;
	localparam logic [1:0] TRIG_START  = 2'h1;
	localparam logic [1:0] TRIG_PAUSE  = 2'h2;
	localparam logic [1:0] TRIG_RETRIG = 2'h3;
	// generation modes
	localparam logic [2:0] MODE_SINGLE = 3'h0;
	localparam logic [2:0] MODE_FINITE = 3'h1;
	localparam logic [2:0] MODE_CONT   = 3'h2;
	localparam logic [2:0] MODE_IMPL   = 3'h3;
	localparam logic [2:0] MODE_SCLK   = 3'h4;
	// buffer regeneration methods
	localparam logic [1:0] REGEN_STD  = 2'h0;
	localparam logic [1:0] REGEN_FIFO = 2'h1;
	localparam logic [1:0] REGEN_NONE = 2'h2;
	typedef enum logic [2:0] {S_OFF, S_WAIT, S_DELAY, S_FETCH, S_ACTIVE, S_IDLE, S_DONE} cptg_state_t;
endpackage : cptg_pkg

//--- logic/cptg_gen.sv
// one counter channel generating pulse trains on its internal output
// What this block does
// - a pulse counter stops the primary generation once the programmed count is reached
// - retriggerable mode emits one or a programmed number of pulses per gate trigger
// - delay and pulse width are counted in active source edges
// - an option applies the initial delay on every trigger or only the first
// - in retriggerable mode gate is ignored while generating; afterwards wait for the next trigger
// - pause trigger is unavailable in retriggerable mode
// - continuous mode waits the programmed delay ticks after arming
// - high and low widths programmable; source edge rising or falling
// - continuous generation starts on arming or on a gate start trigger
// - gate as pause trigger halts counting while active, then resumes
// - output frequency is source frequency divided by high plus low widths
// - each implicit buffered sample makes one pulse, back to back
// - finite implicit mode stops after the programmed number of samples
// - implicit buffered trains ignore the static pulse settings
// - sample clocked trains run the static settings until the first sample clock
// - a sample clock takes effect only after the current pulse completes
// - after the last finite sample, its settings repeat until stopped
// - standard regeneration keeps accepting host samples during output
// - fifo regeneration replays the loaded buffer and refuses new samples
// - non-regeneration never repeats samples and flags underflow when starved
// - continuous buffered generation runs until explicitly stopped
// - counts are 32 bits wide
`timescale 1ns/1ps
module cptg_gen
	import cptg_pkg::*;
#(
	parameter int CW         = 32,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	input  wire logic [7:0]    addr_in,
	input  wire logic [31:0]   wdata_in,
	input  wire logic          wr_in,
	input  wire logic          rd_in,
	output logic      [31:0]   rdata_out,
	input  wire logic          source_in,
	input  wire logic          gate_in,
	input  wire logic          sample_clk_in,
	input  wire logic          smp_valid_in,
	input  wire logic [CW-1:0] smp_idle_in,
	input  wire logic [CW-1:0] smp_active_in,
	output logic               smp_ready_out,
	output logic               pulse_out
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int LW = AW + 1;
	logic [31:0]         ctrl;
	logic [CW-1:0]       delay_r, act_r, idl_r, count_r;
	logic [2:0]          s1, s2, s3, lvl, rise, fall;
	logic                src_tick, gate_edge, sclk_edge, paused;
	logic                armed;
	logic [1:0]          trig, regen;
	logic [2:0]          mode;
	cptg_state_t         state;
	logic [CW-1:0]       tcnt, cur_act, cur_idl, pulses, samples;
	logic                first_done, sc_pend, underflow, tick_end;
	logic [2*CW-1:0]     mem [FIFO_DEPTH];
	logic [AW-1:0]       wr_ptr, rd_ptr, rp_off, rd_idx;
	logic [LW-1:0]       level;
	logic [2*CW-1:0]     head;
	logic                avail, push, take, pop, fetch_take, sclk_take, sc_fin;
	logic                fin_stop, running;
	logic [CW-1:0]       count_lim;
	// count reload: the phase lasts v ticks, zero is stretched to one tick
	function automatic logic [CW-1:0] ld(input logic [CW-1:0] v);
		return (v == '0) ? '0 : v - 1'b1;
	endfunction : ld

	// control field decode
	assign armed = ctrl[CTRL_ARM];
	assign trig  = ctrl[CTRL_TRIG_LSB +: 2];
	assign mode  = ctrl[CTRL_MODE_LSB +: 3];
	assign regen = ctrl[CTRL_REGEN_LSB +: 2];

	// pin synchronisers: source, gate, sample clock; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			logic pin;
			assign pin = (gi == 0) ? source_in : (gi == 1) ? gate_in : sample_clk_in;
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					s1[gi]  <= 1'b0;
					s2[gi]  <= 1'b0;
					s3[gi]  <= 1'b0;
					lvl[gi] <= 1'b0;
				end else begin
					s1[gi] <= pin;
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi])
						lvl[gi] <= s3[gi];
				end
			end
			assign rise[gi] = (s2[gi] == s3[gi]) && s3[gi] && !lvl[gi];
			assign fall[gi] = (s2[gi] == s3[gi]) && !s3[gi] && lvl[gi];
		end
	endgenerate

	assign src_tick  = ctrl[CTRL_SRC_FALL] ? fall[0] : rise[0];
	assign gate_edge = ctrl[CTRL_GATE_FALL] ? fall[1] : rise[1];
	assign sclk_edge = ctrl[CTRL_SCLK_FALL] ? fall[2] : rise[2];

	// pause only exists when the gate is used as the pause trigger
	assign paused = (trig == TRIG_PAUSE) && (lvl[1] ^ ctrl[CTRL_GATE_FALL]);

	// a paused counter ignores source ticks
	assign tick_end = src_tick && !paused && (tcnt == '0);

	// sample fifo; standard and non-regen modes drain it as pulses go out
	assign avail  = (level != '0);
	assign rd_idx = rd_ptr + rp_off;
	assign head   = mem[rd_idx];
	// a loaded regeneration buffer is locked while armed
	assign smp_ready_out = (level != LW'(FIFO_DEPTH)) && !(regen == REGEN_FIFO && armed);
	assign push = smp_valid_in && smp_ready_out;
	// nothing is consumed outside an armed generation
	assign fetch_take = armed && (state == S_FETCH) && avail;
	// finite sample clocked train stops taking samples after the last
	assign sc_fin    = ctrl[CTRL_FIN_BUF] && (samples >= count_r);
	// a pending sample is applied only at the end of the active phase
	assign sclk_take = armed && (state == S_ACTIVE) && tick_end && (mode == MODE_SCLK)
			&& sc_pend && avail && !sc_fin;
	assign take = fetch_take || sclk_take;
	// replay from the fifo without consuming it
	assign pop  = take && (regen != REGEN_FIFO);

	// fifo storage and pointers
	always_ff @(posedge clk_in) begin
		if (push)
			mem[wr_ptr] <= {smp_idle_in, smp_active_in};
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			level <= level + LW'(push) - LW'(pop);
		end
	end

	// replay offset wraps at the number of loaded samples
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !armed)
			rp_off <= '0;
		else if (take && regen == REGEN_FIFO)
			rp_off <= (LW'(rp_off) + 1'b1 == level) ? '0 : rp_off + 1'b1;
	end

	// the pulse counter decides when the train is complete
	assign count_lim = (mode == MODE_SINGLE) ? CW'(1) : count_r;
	// finite implicit stops after the programmed sample count; continuous never does
	assign fin_stop = ((mode == MODE_SINGLE || mode == MODE_FINITE) && (pulses + 1'b1 >= count_lim))
			|| (mode == MODE_IMPL && ctrl[CTRL_FIN_BUF] && samples >= count_r);
	assign running  = (state == S_DELAY) || (state == S_FETCH) || (state == S_ACTIVE) || (state == S_IDLE);

	// main generation sequence
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state      <= S_OFF;
			tcnt       <= '0;
			cur_act    <= '0;
			cur_idl    <= '0;
			pulses     <= '0;
			samples    <= '0;
			first_done <= 1'b0;
			pulse_out  <= 1'b0;
		end else if (!armed) begin
			// disarm returns the output to idle at once
			state     <= S_OFF;
			pulse_out <= 1'b0;
		end else begin
			case (state)
				S_OFF: begin
					pulses     <= '0;
					samples    <= '0;
					first_done <= 1'b0;
					cur_act    <= act_r;
					cur_idl    <= idl_r;
					// start immediately or wait for a gate trigger
					if (trig == TRIG_START || trig == TRIG_RETRIG)
						state <= S_WAIT;
					else if (mode == MODE_IMPL)
						state <= S_FETCH;
					else begin
						state <= S_DELAY;
						tcnt  <= ld(delay_r);
					end
				end
				S_WAIT: begin
					// only a waiting counter takes a trigger
					if (gate_edge) begin
						pulses     <= '0;
						first_done <= 1'b1;
						if (mode == MODE_IMPL)
							state <= S_FETCH;
						// delay on every trigger or only the first
						else if (!first_done || ctrl[CTRL_EVERY]) begin
							state <= S_DELAY;
							tcnt  <= ld(delay_r);
						end else begin
							state <= S_IDLE;
							tcnt  <= ld(cur_idl);
						end
					end
				end
				S_DELAY: begin
					// delay ends on the counted source edge
					if (tick_end) begin
						state     <= S_ACTIVE;
						tcnt      <= ld(cur_act);
						pulse_out <= 1'b1;
					end else if (src_tick && !paused)
						tcnt <= tcnt - 1'b1;
				end
				S_FETCH: begin
					// buffered samples replace the static settings
					if (avail) begin
						cur_idl <= head[2*CW-1:CW];
						cur_act <= head[CW-1:0];
						samples <= samples + 1'b1;
						state   <= S_IDLE;
						tcnt    <= ld(head[2*CW-1:CW]);
					end
				end
				S_ACTIVE: begin
					if (tick_end) begin
						pulse_out <= 1'b0;
						pulses    <= pulses + 1'b1;
						if (fin_stop)
							// retrigger mode rearms for the next trigger
							state <= (trig == TRIG_RETRIG) ? S_WAIT : S_DONE;
						else if (mode == MODE_IMPL)
							// next sample fetched with no idle gap added
							state <= S_FETCH;
						else if (sclk_take) begin
							cur_idl <= head[2*CW-1:CW];
							cur_act <= head[CW-1:0];
							samples <= samples + 1'b1;
							state   <= S_IDLE;
							tcnt    <= ld(head[2*CW-1:CW]);
						end else begin
							// high M then low N ticks per period
							state <= S_IDLE;
							tcnt  <= ld(cur_idl);
						end
					end else if (src_tick && !paused)
						tcnt <= tcnt - 1'b1;
				end
				S_IDLE: begin
					if (tick_end) begin
						state     <= S_ACTIVE;
						tcnt      <= ld(cur_act);
						pulse_out <= 1'b1;
					end else if (src_tick && !paused)
						tcnt <= tcnt - 1'b1;
				end
				S_DONE: state <= S_DONE;
				default: state <= S_OFF;
			endcase
		end
	end

	// sample clock edges are only noted, the static pattern runs until then
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !armed)
			sc_pend <= 1'b0;
		else if (sclk_edge && running && mode == MODE_SCLK)
			sc_pend <= 1'b1;
		else if (sclk_take)
			sc_pend <= 1'b0;
	end

	// starved non-regen output flags underflow; a new event beats the clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			underflow <= 1'b0;
		else if (regen == REGEN_NONE && armed && !avail && (state == S_FETCH
				|| (state == S_ACTIVE && tick_end && mode == MODE_SCLK && sc_pend && !sc_fin)))
			underflow <= 1'b1;
		else if (wr_in && addr_in == REG_STATUS && wdata_in[ST_UNDER])
			underflow <= 1'b0;
	end

	// register writes; all counts hold CW bits
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl    <= CTRL_RESET;
			delay_r <= CW'(TICKS_RESET);
			act_r   <= CW'(TICKS_RESET);
			idl_r   <= CW'(TICKS_RESET);
			count_r <= CW'(COUNT_RESET);
		end else if (wr_in) begin
			case (addr_in)
				REG_CTRL:   ctrl    <= wdata_in;
				REG_DELAY:  delay_r <= CW'(wdata_in);
				REG_ACTIVE: act_r   <= CW'(wdata_in);
				REG_IDLE:   idl_r   <= CW'(wdata_in);
				REG_COUNT:  count_r <= CW'(wdata_in);
				default:    ctrl    <= ctrl;
			endcase
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !rd_in)
			rdata_out <= '0;
		else begin
			case (addr_in)
				REG_CTRL:   rdata_out <= ctrl;
				REG_DELAY:  rdata_out <= 32'(delay_r);
				REG_ACTIVE: rdata_out <= 32'(act_r);
				REG_IDLE:   rdata_out <= 32'(idl_r);
				REG_COUNT:  rdata_out <= 32'(count_r);
				REG_STATUS: rdata_out <= 32'({state == S_WAIT, underflow, state == S_DONE, pulse_out, running});
				REG_PULSES: rdata_out <= 32'(pulses);
				REG_LEVEL:  rdata_out <= 32'(level);
				default:    rdata_out <= '0;
			endcase
		end
	end
	// checks on the generation sequence
	default clocking dcb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence seq_last_pulse;
		armed && state == S_ACTIVE && tick_end && fin_stop && trig != TRIG_RETRIG;
	endsequence
	sequence seq_delay_done;
		armed && state == S_DELAY && tick_end;
	endsequence

	a_disarm_idle: assert property (!armed |=> !pulse_out && !running)
		else $error("output active while disarmed");
	a_delay_to_width: assert property (seq_delay_done |=> pulse_out && tcnt == ld(cur_act))
		else $error("width not loaded after delay");
	a_gate_ignored: assert property (armed && state == S_ACTIVE && gate_edge && !tick_end
			##1 armed |-> state == S_ACTIVE)
		else $error("gate disturbed a running pulse");
	a_finite_stop: assert property (seq_last_pulse ##1 armed |-> state == S_DONE && !pulse_out)
		else $error("finite train did not stop");
	a_no_pause_retrig: assert property (trig == TRIG_RETRIG |-> !paused)
		else $error("pause active in retrigger mode");
	a_pause_hold: assert property (armed && paused && (state == S_DELAY || state == S_ACTIVE || state == S_IDLE)
			##1 armed |-> state == $past(state) && tcnt == $past(tcnt))
		else $error("count moved while paused");
	a_regen_locked: assert property (regen == REGEN_FIFO && armed |-> !smp_ready_out)
		else $error("fifo accepts data during regeneration");
	a_underflow_set: assert property (armed && state == S_FETCH && !avail && regen == REGEN_NONE
			|=> underflow)
		else $error("underflow not flagged");
	a_retrig_rearm: assert property (armed && state == S_ACTIVE && tick_end && fin_stop
			&& trig == TRIG_RETRIG ##1 armed |-> state == S_WAIT)
		else $error("retrigger did not rearm");
endmodule : cptg_gen

//--- test/cptg_receiver.sv
// model of the equipment that receives the generated pulse output
`timescale 1ns/1ps
module cptg_receiver (
	input  wire logic clk_in,
	input  wire logic pulse_in,
	output int        rises_out,
	output int        high_out,
	output int        low_out
);
	int   run_len;
	logic last;

	initial begin
		rises_out = 0;
		high_out  = 0;
		low_out   = 0;
		run_len   = 0;
		last      = 1'b0;
	end

	// phase lengths in clock cycles; an unknown level never counts as a rise
	always @(posedge clk_in) begin
		if (pulse_in === last) begin
			run_len <= run_len + 1;
		end else begin
			if (last === 1'b1)
				high_out <= run_len;
			if (last === 1'b0 && pulse_in === 1'b1) begin
				low_out   <= run_len;
				rises_out <= rises_out + 1;
			end
			run_len <= 1;
		end
		last <= pulse_in;
	end
endmodule : cptg_receiver

//--- test/test_cptg_gen.sv
// self-checking bench for one pulse train generator channel
`timescale 1ns/1ps
module test_cptg_gen
	import cptg_pkg::*;
;
	typedef struct packed {
		logic [31:0] active;
		logic [31:0] idle;
		logic [31:0] count;
	} cptg_row_t;

	localparam int TICK  = 8;
	localparam int LIMIT = 60000;
	localparam int FIFO_FILL = 16;
	localparam cptg_row_t ROWS [3] = '{'{32'h2, 32'h3, 32'h3}, '{32'h4, 32'h1, 32'h1}, '{32'h1, 32'h2, 32'h5}};
	localparam logic [7:0] RA [6] = '{REG_CTRL, REG_DELAY, REG_ACTIVE, REG_IDLE, REG_COUNT, REG_LEVEL};
	localparam logic [31:0] RV [6] = '{CTRL_RESET, TICKS_RESET, TICKS_RESET, TICKS_RESET, COUNT_RESET, 32'h0};

	logic        clk_in;
	logic        rst_n_in;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [31:0] rdata_out;
	logic        source_in;
	logic        gate_in;
	logic        sample_clk_in;
	logic        smp_valid_in;
	logic [31:0] smp_idle_in;
	logic [31:0] smp_active_in;
	logic        smp_ready_out;
	logic        pulse_out;
	logic [2:0]  src_cnt;
	logic [31:0] d;
	int          rises;
	int          high;
	int          low;
	int          base;
	int          fails;
	int          tests_run;
	int          cycles;

	cptg_gen i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .source_in(source_in), .gate_in(gate_in),
		.sample_clk_in(sample_clk_in), .smp_valid_in(smp_valid_in), .smp_idle_in(smp_idle_in),
		.smp_active_in(smp_active_in), .smp_ready_out(smp_ready_out), .pulse_out(pulse_out));

	cptg_receiver i_rx (.clk_in(clk_in), .pulse_in(pulse_out), .rises_out(rises), .high_out(high), .low_out(low));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// source timebase of eight clocks, slow enough for the input synchroniser
	always @(posedge clk_in) begin
		src_cnt   <= src_cnt + 3'h1;
		source_in <= src_cnt[2];
	end

	// a hang counts as a mismatch
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails = fails + 1;
			stop_test();
		end
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_in);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= v;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask : rd_reg

	task push(input logic [31:0] idle, input logic [31:0] act);
		@(posedge clk_in);
		smp_valid_in  <= 1'b1;
		smp_idle_in   <= idle;
		smp_active_in <= act;
		// hold the offer until the fifo takes it
		do @(posedge clk_in); while (smp_ready_out !== 1'b1);
		smp_valid_in <= 1'b0;
	endtask : push

	// bounded poll of one status bit
	task wait_bit(input int b);
		int n;
		n = 0;
		d = 32'h0;
		while (d[b] !== 1'b1 && n < 300) begin
			rd_reg(REG_STATUS, d);
			n++;
		end
	endtask : wait_bit

	task gate_pulse();
		@(posedge clk_in);
		gate_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		gate_in <= 1'b0;
	endtask : gate_pulse

	task stop_test();
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	initial begin
		{rst_n_in, addr_in, wdata_in, wr_in, rd_in, gate_in, sample_clk_in} = '0;
		{smp_valid_in, smp_idle_in, smp_active_in, src_cnt, source_in} = '0;
		{fails, tests_run, cycles} = '0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// finite trains: width and count per row
		for (int i = 0; i < 3; i++) begin
			wr_reg(REG_ACTIVE, ROWS[i].active);
			wr_reg(REG_IDLE, ROWS[i].idle);
			wr_reg(REG_COUNT, ROWS[i].count);
			base = rises;
			wr_reg(REG_CTRL, 32'h0000_0041);
			wait_bit(ST_DONE);
			check("finite rises", 32'(rises - base), ROWS[i].count);
			check("finite high", 32'(high), ROWS[i].active * TICK);
			if (ROWS[i].count > 1)
				check("finite low", 32'(low), ROWS[i].idle * TICK);
			wr_reg(REG_CTRL, 32'h0);
			repeat (4) @(posedge clk_in);
			check("idle after stop", {31'h0, pulse_out}, 32'h1 & 32'h0);
		end
		// continuous train: period is high plus low ticks
		wr_reg(REG_DELAY, 32'h3);
		wr_reg(REG_ACTIVE, 32'h2);
		wr_reg(REG_IDLE, 32'h3);
		base = rises;
		wr_reg(REG_CTRL, 32'h0000_0083); // falling source edge
		repeat (300) @(posedge clk_in);
		check("cont high", 32'(high), 32'd16);
		check("cont low", 32'(low), 32'd24);
		check("cont runs", {31'h0, (rises - base) >= 5}, 32'h1);
		rd_reg(REG_STATUS, d);
		check("cont run bit", {31'h0, d[ST_RUN]}, 32'h1);
		// pause trigger held active from arming, then released
		wr_reg(REG_CTRL, 32'h0);
		gate_in <= 1'b1;
		base = rises;
		wr_reg(REG_CTRL, 32'h0000_0091);
		repeat (200) @(posedge clk_in);
		check("paused", 32'(rises - base), 32'h0);
		gate_in <= 1'b0;
		repeat (200) @(posedge clk_in);
		check("resumed", {31'h0, (rises - base) >= 3}, 32'h1);
		// retrigger with a stray gate pulse inside each generation
		wr_reg(REG_CTRL, 32'h0);
		wr_reg(REG_DELAY, 32'h2);
		wr_reg(REG_ACTIVE, 32'h3);
		base = rises;
		wr_reg(REG_CTRL, 32'h0000_0039);
		repeat (2) begin
			gate_pulse();
			repeat (24) @(posedge clk_in);
			gate_pulse();
			repeat (120) @(posedge clk_in);
		end
		check("retrig rises", 32'(rises - base), 32'h2);
		check("retrig high", 32'(high), 32'd24);
		// implicit buffered finite train; static width deliberately differs
		wr_reg(REG_CTRL, 32'h0);
		wr_reg(REG_ACTIVE, 32'h5);
		wr_reg(REG_COUNT, 32'h3);
		push(32'h2, 32'h2);
		push(32'h3, 32'h4);
		push(32'h2, 32'h2);
		rd_reg(REG_LEVEL, d);
		check("level loaded", d, 32'h3);
		base = rises;
		wr_reg(REG_CTRL, 32'h0000_02c1);
		wait_bit(ST_DONE);
		check("impl rises", 32'(rises - base), 32'h3);
		check("impl high", 32'(high), 32'd16);
		check("impl low", 32'(low), 32'd16);
		// non-regeneration starved after one sample
		wr_reg(REG_CTRL, 32'h0);
		push(32'h2, 32'h2);
		wr_reg(REG_CTRL, 32'h0000_08c1);
		repeat (200) @(posedge clk_in);
		rd_reg(REG_STATUS, d);
		check("underflow", {31'h0, d[ST_UNDER]}, 32'h1);
		wr_reg(REG_CTRL, 32'h0);
		repeat (8) @(posedge clk_in);
		check("idle disarmed", {31'h0, pulse_out}, 32'h0);
		wr_reg(REG_STATUS, 32'h0000_0008);
		rd_reg(REG_STATUS, d);
		check("underflow cleared", {31'h0, d[ST_UNDER]}, 32'h0);
		// fill the fifo, then replay it from the fifo alone
		repeat (FIFO_FILL) push(32'h2, 32'h2);
		@(negedge clk_in);
		check("full refuses", {31'h0, smp_ready_out}, 32'h0);
		rd_reg(REG_LEVEL, d);
		check("level full", d, 32'd16);
		base = rises;
		wr_reg(REG_CTRL, 32'h0000_04c1);
		repeat (300) @(posedge clk_in);
		check("regen refuses", {31'h0, smp_ready_out}, 32'h0);
		check("regen replays", {31'h0, (rises - base) >= 3}, 32'h1);
		rd_reg(REG_LEVEL, d);
		check("replay keeps fifo", d, 32'h10);
		// second reset in mid-run: register defaults and emptied fifo
		rst_n_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd_reg(RA[i], d);
			check("reset value", d, RV[i]);
		end
		rd_reg(8'h40, d);
		check("unmapped read", d, 32'h0);
		check("ready after reset", {31'h0, smp_ready_out}, 32'h1);
		// sample clocked finite train: static pattern until the first sample clock
		wr_reg(REG_ACTIVE, 32'h1);
		push(32'h3, 32'h3);
		push(32'h2, 32'h2);
		wr_reg(REG_CTRL, 32'h0000_0301);
		repeat (100) @(posedge clk_in);
		check("static high", 32'(high), 32'h8);
		// a count of one leaves the second sample unused however many clocks follow
		for (int k = 0; k < 2; k++) begin
			sample_clk_in <= 1'b1;
			repeat (8) @(posedge clk_in);
			sample_clk_in <= 1'b0;
			repeat (150) @(posedge clk_in);
			check("sclk high", 32'(high), 32'h18);
			check("sclk low", 32'(low), 32'h18);
		end
		rd_reg(REG_LEVEL, d);
		check("last sample holds", d, 32'h1);
		// a regenerating fifo refuses samples even while it has room
		wr_reg(REG_CTRL, 32'h0);
		wr_reg(REG_CTRL, 32'h0000_04c1);
		@(negedge clk_in);
		check("regen locked", {31'h0, smp_ready_out}, 32'h0);
		stop_test();
	end
endmodule : test_cptg_gen
